// ==== sar_adc_pkg.sv ====
/*
   sar_adc_pkg: constants shared by the converter control and the
   successive-approximation engine.
   Assumes a 200 MHz system clock; all times are in nanoseconds.
*/
package sar_adc_pkg;

   // ------------------------------------------------------------------
   // word layout
   // ------------------------------------------------------------------
   localparam int unsigned RES_BITS  = 16;
   localparam int unsigned CODE_MSB  = RES_BITS - 1;
   localparam logic [RES_BITS-1:0] CODE_ZERO = 16'h0000;
   localparam logic [RES_BITS-1:0] MSB_TRIAL = 16'h8000;
   localparam logic [3:0]  TOP_BIT   = 4'hF;
   localparam logic [3:0]  LAST_BIT  = 4'h0;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned T_CONV_MAX_NS = 527;
   // longest time rounds down to whole cycles
   localparam int unsigned CONV_CYC      = T_CONV_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned STEP_CYC      = CONV_CYC / RES_BITS;
   localparam logic [3:0]  STEP_LAST     = 4'(STEP_CYC - 1);
   localparam logic [3:0]  CNT_ZERO      = 4'h0;
   localparam logic [3:0]  CNT_ONE       = 4'h1;

   // ------------------------------------------------------------------
   // states
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      ENG_IDLE  = 3'b001,
      ENG_TRIAL = 3'b010,
      ENG_DONE  = 3'b100
   } eng_state_t;

   typedef enum logic [1:0] {
      CTL_NAP  = 2'b01,
      CTL_CONV = 2'b10
   } ctl_state_t;

endpackage : sar_adc_pkg

// ==== sar_engine_if.sv ====
/*
   sar_engine_if: start/result handshake and analog-side signals between
   the converter control and the successive-approximation engine.
   Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface sar_engine_if;
   import sar_adc_pkg::*;
   logic                start;   // one-cycle pulse: begin a search
   logic                done;    // one-cycle pulse: code valid
   logic [RES_BITS-1:0] code;    // finished two's complement code
   logic [RES_BITS-1:0] dac;     // trial word driving the cap array
   logic                cmp;     // comparator level, already synced

   modport ctrl   (output start, cmp, input done, code, dac);
   modport engine (input start, cmp, output done, code, dac);
endinterface : sar_engine_if

// ==== sar_engine.sv ====
/*
   sar_engine: binary search over the capacitive DAC, one bit per step,
   each step timed by an internal count of the system clock.
   Assumes the comparator level on the interface is already synchronised
   and settles within one step.
*/
`timescale 1ns/1ps
module sar_engine
   import sar_adc_pkg::*;
(
   // clock and reset
   input  wire logic  i_clk,
   input  wire logic  i_rst_n,
   // control side
   sar_engine_if.engine eif
);
   import sar_adc_pkg::*;

   eng_state_t          state_r;
   logic [3:0]          cnt_r;
   logic [3:0]          bit_r;
   logic [RES_BITS-1:0] dac_r;
   logic [RES_BITS-1:0] code_r;
   logic                done_r;
   logic                step_end;

   assign step_end = (state_r == ENG_TRIAL) && (cnt_r == STEP_LAST);
   assign eif.dac  = dac_r;
   assign eif.code = code_r;
   assign eif.done = done_r;

   // ------------------------------------------------------------------
   // search sequencer
   // ------------------------------------------------------------------
   // step counter: no external clock is needed during conversion
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || state_r != ENG_TRIAL || step_end)
         cnt_r <= CNT_ZERO;
      else
         cnt_r <= cnt_r + CNT_ONE;
   end

   // state, trial word and bit index
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         state_r <= ENG_IDLE;
         dac_r   <= CODE_ZERO;
         bit_r   <= TOP_BIT;
      end
      else
      begin
         case (state_r)
            ENG_IDLE:
            begin
               if (eif.start)
               begin
                  dac_r   <= MSB_TRIAL;   // half scale first
                  bit_r   <= TOP_BIT;
                  state_r <= ENG_TRIAL;
               end
            end
            ENG_TRIAL:
            begin
               if (step_end)
               begin
                  // keep the bit only if the input is at or above the trial
                  dac_r[bit_r] <= eif.cmp;
                  if (bit_r == LAST_BIT)
                     state_r <= ENG_DONE;
                  else
                  begin
                     dac_r[bit_r - CNT_ONE] <= 1'b1;
                     bit_r <= bit_r - CNT_ONE;
                  end
               end
            end
            ENG_DONE:
               state_r <= ENG_IDLE;
            default:
               state_r <= ENG_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // result word
   // ------------------------------------------------------------------
   // array is offset binary; flipping the msb gives two's complement
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         code_r <= CODE_ZERO;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= (state_r == ENG_DONE);
         if (state_r == ENG_DONE)
            code_r <= {~dac_r[CODE_MSB], dac_r[CODE_MSB-1:0]};
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_search_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state_r == ENG_IDLE && eif.start) |=> dac_r == MSB_TRIAL)
      else $error("search did not begin at half scale");

   a_twos_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      done_r |-> code_r[CODE_MSB] != $past(dac_r[CODE_MSB]))
      else $error("result msb not inverted to two's complement");

   a_conv_time: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state_r == ENG_IDLE && eif.start) |-> ##[90:100] done_r)
      else $error("conversion did not finish in its time");

endmodule : sar_engine

// ==== sar_adc_serial_readout.sv ====
/*
   sar_adc_serial_readout: convert-start handling, busy flag, nap state
   and serial result / daisy-chain shifter of a 16-bit SAR converter.
   Assumes all pins, including the host's serial clock, are asynchronous
   and slow enough to be sampled by the 200 MHz system clock.

// Operation
// - convert rising edge wakes the part and starts a conversion
// - chain select low: shared pin enables the serial output
// - chain select high: shared pin is the upstream serial input
// - busy rises at conversion start, falls when it completes
// - enabled output shifts own or chained data msb first per edge
// - result is two's complement over 65536 codes
// - search tests binary weights from half down to 1/65536
// - finished 16-bit code is loaded into the serial shifter
// - conversion timed internally; host gives only the start edge
// - result readable in the same cycle, no pipeline delay
// - device naps between conversions, wakes on next start
// - normal mode drives output only while enable is low
// - chain mode captures upstream bit on each serial clock rise
*/
`timescale 1ns/1ps
module sar_adc_serial_readout
   import sar_adc_pkg::*;
(
   // clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_rst_n,
   // host pins
   input  wire logic                i_convert_start,
   input  wire logic                i_chain_select,
   input  wire logic                i_bus_enable_or_chain_input,
   input  wire logic                i_sck,
   output logic                     o_busy,
   output logic                     o_serial_result_out,
   output logic                     o_serial_result_oe,
   // analog core
   input  wire logic                i_comparator,
   output logic [RES_BITS-1:0]      o_capacitive_dac,
   output logic                     o_nap
);
   import sar_adc_pkg::*;

   sar_engine_if eif ();

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   logic [2:0] cnv_sync_r;   // third stage only feeds the edge detector
   logic [2:0] sck_sync_r;
   logic [1:0] chain_sync_r;
   logic [1:0] shared_sync_r;
   logic [1:0] cmp_sync_r;
   logic       cnv_rise;
   logic       sck_rise;
   logic       chain_mode;
   logic       shared_pin;

   // first stages are read only by the second stages
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         cnv_sync_r    <= 3'h0;
         sck_sync_r    <= 3'h0;
         chain_sync_r  <= 2'h0;
         shared_sync_r <= 2'h3;
         cmp_sync_r    <= 2'h0;
      end
      else
      begin
         cnv_sync_r    <= {cnv_sync_r[1:0], i_convert_start};
         sck_sync_r    <= {sck_sync_r[1:0], i_sck};
         chain_sync_r  <= {chain_sync_r[0], i_chain_select};
         shared_sync_r <= {shared_sync_r[0], i_bus_enable_or_chain_input};
         cmp_sync_r    <= {cmp_sync_r[0], i_comparator};
      end
   end

   assign cnv_rise   = cnv_sync_r[1] & ~cnv_sync_r[2];
   assign sck_rise   = sck_sync_r[1] & ~sck_sync_r[2];
   assign chain_mode = chain_sync_r[1];
   assign shared_pin = shared_sync_r[1];
   assign eif.cmp    = cmp_sync_r[1];

   // ------------------------------------------------------------------
   // conversion control
   // ------------------------------------------------------------------
   ctl_state_t state_r;
   logic       start;

   // a start edge during a conversion is ignored; the host spaces them
   assign start     = cnv_rise && (state_r == CTL_NAP);
   assign eif.start = start;

   // nap until a start edge, convert until the engine reports done
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         state_r <= CTL_NAP;
      else
      begin
         case (state_r)
            CTL_NAP:
               if (start)
                  state_r <= CTL_CONV;
            CTL_CONV:
               if (eif.done)
                  state_r <= CTL_NAP;
            default:
               state_r <= CTL_NAP;
         endcase
      end
   end

   assign o_busy           = (state_r == CTL_CONV);
   assign o_nap            = (state_r == CTL_NAP);
   assign o_capacitive_dac = eif.dac;

   sar_engine u_engine
   (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .eif     (eif.engine)
   );

   // ------------------------------------------------------------------
   // serial shifter
   // ------------------------------------------------------------------
   logic [RES_BITS-1:0] shift_r;
   logic                chain_bit;

   // in normal mode zeros trail the word; the shared pin is an enable
   assign chain_bit = chain_mode & shared_pin;

   // the code lands the cycle busy falls, so msb leads every clock;
   // serial edges during a conversion are ignored, the host keeps
   // the clock quiet then anyway
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         shift_r <= CODE_ZERO;
      else if (eif.done)
         shift_r <= eif.code;
      else if (sck_rise && state_r == CTL_NAP)
         shift_r <= {shift_r[CODE_MSB-1:0], chain_bit};
   end

   assign o_serial_result_out = shift_r[CODE_MSB];
   // chain mode always drives; normal mode follows the low enable
   assign o_serial_result_oe  = chain_mode | ~shared_pin;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence conv_started;
      cnv_rise && o_nap;
   endsequence

   sequence conv_finished;
      eif.done;
   endsequence

   a_busy_on_start: assert property (conv_started |=>
      o_busy && !o_nap)
      else $error("busy did not rise after convert edge");

   a_busy_span: assert property (conv_started |=> o_busy[*8])
      else $error("busy dropped early in a conversion");

   a_busy_release: assert property (conv_finished |=>
      !o_busy && o_nap)
      else $error("busy stayed high after conversion done");

   a_msb_ready: assert property (conv_finished |=>
      o_serial_result_out == $past(eif.code[CODE_MSB]))
      else $error("msb not on output when busy fell");

   a_code_loaded: assert property (conv_finished |=>
      shift_r == $past(eif.code))
      else $error("code not loaded into shifter");

   a_shift_order: assert property ((sck_rise && o_nap && !eif.done) |=>
      shift_r == {$past(shift_r[CODE_MSB-1:0]), $past(chain_bit)})
      else $error("shifter did not advance msb first");

   a_chain_capture: assert property ((sck_rise && o_nap && chain_mode
      && !eif.done) |=> shift_r[0] == $past(shared_pin))
      else $error("upstream bit not captured");

   a_normal_enable: assert property (!chain_mode |->
      o_serial_result_oe == !shared_pin)
      else $error("output enable does not follow bus enable");

   a_chain_drive: assert property (chain_mode |-> o_serial_result_oe)
      else $error("output not driven in chain mode");

   // the word must stand between serial edges so the host can sample
   // it anywhere in the low half of its clock
   sequence word_idle;
      o_nap && !sck_rise && !eif.done;
   endsequence

   a_word_stands: assert property (word_idle |=>
      $stable(o_serial_result_out))
      else $error("serial output changed without a clock edge");

   a_conv_length: assert property (conv_started |->
      ##[90:105] conv_finished)
      else $error("conversion exceeded its time budget");

   a_dac_first: assert property (conv_started |=>
      o_capacitive_dac == MSB_TRIAL)
      else $error("array did not start at half scale");

   // the code must be ready before busy falls: no pipeline latency
   a_done_busy: assert property (conv_finished |-> o_busy)
      else $error("result came after busy fell");

endmodule : sar_adc_serial_readout

// ==== sar_host_model.sv ====
/*
   sar_host_model: host side of the converter pins; makes the convert
   edge and bursts of a 48 ns serial clock, collects the output word.
   Assumes the bench calls its tasks and spaces starts by over 1 us.
*/
`timescale 1ns/1ps
module sar_host_model
(
   // pins toward the converter
   input  wire logic i_clk,
   input  wire logic i_sdo,
   input  wire logic i_chain_en,
   output logic      o_convert_start,
   output logic      o_sck,
   output logic      o_shared
);
   // ------------------------------------------------------------------
   // idle levels
   // ------------------------------------------------------------------
   // serial clock stands low between frames, never free running
   initial
   begin
      o_convert_start = 1'b0;
      o_sck           = 1'b0;
      o_shared        = 1'b1;
   end

   // ------------------------------------------------------------------
   // frames
   // ------------------------------------------------------------------
   // start pulse, serial clock kept still while it is high
   task automatic pulse_convert();
      @(negedge i_clk);
      o_convert_start = 1'b1;
      repeat (10) @(negedge i_clk);
      o_convert_start = 1'b0;
   endtask : pulse_convert

   // n bits msb first; upstream bits fed at the falling sck edge
   task automatic shift_word(input int n, input logic [31:0] up_word,
                             output logic [31:0] got);
      got = 32'h0000_0000;
      for (int i = n - 1; i >= 0; i--)
      begin
         if (i_chain_en)
            o_shared = up_word[i];
         #24;
         got[i] = i_sdo;
         o_sck  = 1'b1;
         #24;
         o_sck  = 1'b0;
      end
      // released data line must not keep its last value
      if (i_chain_en)
         o_shared = ~o_shared;
   endtask : shift_word
endmodule : sar_host_model

// ==== test_sar_adc_serial_readout.sv ====
/*
   test_sar_adc_serial_readout: self-checking bench for the converter
   control and serial readout, with a comparator model on the dac.
   Assumes the host model above and the design package.
*/
`timescale 1ns/1ps
module test_sar_adc_serial_readout;
   import sar_adc_pkg::*;

   // ------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------
   logic        i_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        chain_sel = 1'b0;
   logic        rd_en_n = 1'b1;
   logic [15:0] level = 16'h0000;
   wire         convert_start, sck, shared, busy, serial_result_out, oe, nap;
   wire  [15:0] dac;
   wire         shared_pin;
   int          bad_count = 0;
   int          n_tests = 0;
   int          nap_bad = 0;

   always #2.5 i_clk = ~i_clk;

   // comparator model: high while held input is at or above trial word
   assign shared_pin = chain_sel ? shared : rd_en_n;

   sar_adc_serial_readout dut_u (
      .i_clk                       (i_clk),
      .i_rst_n                     (i_rst_n),
      .i_convert_start             (convert_start),
      .i_chain_select              (chain_sel),
      .i_bus_enable_or_chain_input (shared_pin),
      .i_sck                       (sck),
      .o_busy                      (busy),
      .o_serial_result_out         (serial_result_out),
      .o_serial_result_oe          (oe),
      .i_comparator                (dac <= level),
      .o_capacitive_dac            (dac),
      .o_nap                       (nap)
   );

   sar_host_model host_u (
      .i_clk           (i_clk),
      .i_sdo           (serial_result_out),
      .i_chain_en      (chain_sel),
      .o_convert_start (convert_start),
      .o_sck           (sck),
      .o_shared        (shared)
   );

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test

   // counts cycles until busy equals val; a used-up bound ends the run
   task automatic wait_busy(input logic val, input int lim, output int n);
      n = 0;
      while (busy !== val)
      begin
         if (nap !== ~busy)
            nap_bad++;
         @(negedge i_clk);
         n++;
         if (n > lim)
         begin
            bad_count++;
            end_of_test();
         end
      end
   endtask : wait_busy

   // start, time the busy window, return code read over n bits
   task automatic convert_read(input logic [15:0] lvl, input int bits,
                               input logic [31:0] up,
                               output logic [31:0] got);
      int n;
      level = lvl;
      fork
         host_u.pulse_convert();
      join_none
      wait_busy(1'b1, 8, n);
      check({16'h0, dac}, {16'h0, MSB_TRIAL});
      wait_busy(1'b0, 120, n);
      check(32'(n >= 97 && n <= 98), 32'h1);
      check(32'(nap_bad), 32'h0);
      host_u.shift_word(bits, up, got);
      repeat (120) @(negedge i_clk);
   endtask : convert_read

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   // normal mode: extremes and mid codes come back msb first
   task automatic test_normal();
      logic [15:0] lvls [5] = '{16'h0000, 16'hFFFF, 16'h7FFF, 16'h8000,
                               16'hA5C3};
      logic [31:0] got;
      @(negedge i_clk);
      rd_en_n = 1'b0;
      foreach (lvls[k])
      begin
         convert_read(lvls[k], 16, 32'h0, got);
         check(got, {16'h0, lvls[k] ^ 16'h8000});
      end
      check({31'h0, oe}, 32'h1);
      $display("test_normal done");
   endtask : test_normal

   // bus enable high releases the output, low drives it again
   task automatic test_enable();
      rd_en_n = 1'b1;
      repeat (5) @(negedge i_clk);
      check({31'h0, oe}, 32'h0);
      rd_en_n = 1'b0;
      repeat (5) @(negedge i_clk);
      check({31'h0, oe}, 32'h1);
      $display("test_enable done");
   endtask : test_enable

   // chain mode: own word, then upstream bits follow on the output
   task automatic test_chain();
      logic [31:0] got;
      chain_sel = 1'b1;
      rd_en_n   = 1'b1;
      repeat (5) @(negedge i_clk);
      check({31'h0, oe}, 32'h1);
      convert_read(16'h3C5A, 32, 32'h96E1_0000, got);
      check(got, {16'hBC5A, 16'h96E1});
      $display("test_chain done");
   endtask : test_chain

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial
   begin
      repeat (16) @(negedge i_clk);
      i_rst_n = 1'b1;
      repeat (2) @(negedge i_clk);
      test_normal();
      test_enable();
      test_chain();
      end_of_test();
   end
endmodule : test_sar_adc_serial_readout
